//--- rtl/usd_top.sv
// Shadow receive and transmit data port with its APB slave.
//
// Functional notes
// - Sixteen word slots alias one data path.
// - Slot read returns received byte, bits 7:0.
// - No fifo: new byte overwrites, flags overrun.
// - Fifo mode: slot read returns and pops head.
// - Full receive fifo drops arrival, flags overrun.
// - No fifo: one write clears holding empty.
// - No fifo: further writes overwrite pending character.
// - Fifo mode: accepts sixteen characters before full.
// - Write to full transmit fifo is discarded.
`timescale 1ns/1ps
`default_nettype none
`include "usd_regs.svh"

module usd_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire usd_pkg::usd_char_t rx_serial_char,
	input wire logic rx_serial_valid,
	input wire usd_pkg::usd_char_t rx_ir_char,
	input wire logic rx_ir_valid,
	output usd_pkg::usd_char_t tx_char,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic ir_mode,
	output logic irq
);

	// True for any of the sixteen aliased slots.
	function automatic logic is_slot(input logic [31:0] a);
		is_slot = (a >= `USD_SLOT_FIRST) && (a <= `USD_SLOT_LAST) && (a[1:0] == 2'b00);
	endfunction

	// True for any mapped word.
	function automatic logic is_mapped(input logic [31:0] a);
		is_mapped = is_slot(a) || (a == `USD_LINE_STATE_OFS) || (a == `USD_FIFO_CTRL_OFS) ||
			(a == `USD_INT_STS_OFS) || (a == `USD_INT_MASK_OFS);
	endfunction

	// Bus slave state and registered answer.
	usd_pkg::usd_apb_e st_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// Control and status registers.
	logic [4:0] fc_q;
	logic [`USD_IS_W-1:0] sts_q;
	logic [`USD_IS_W-1:0] mask_q;
	logic irq_q;
	logic ovr_q;
	logic hold_empty_prev_q;

	// Non fifo receive holding byte and its ready flag.
	usd_pkg::usd_char_t rx_hold_q;
	logic rdy_q;

	// Transmit output stage toward the serializer.
	usd_pkg::usd_char_t tx_char_q;
	logic tx_valid_q;

	// Fifo wires.
	usd_pkg::usd_char_t rx_head;
	usd_pkg::usd_char_t tx_head;
	logic [`USD_FIFO_CW-1:0] rx_cnt;
	logic [`USD_FIFO_CW-1:0] tx_cnt;

	// Decoded events.
	logic fifo_en;
	logic done;
	logic wr_done;
	logic rd_done;
	logic slot_wr;
	logic slot_rd;
	logic fc_wr;
	logic rx_flush;
	logic tx_flush;
	usd_pkg::usd_char_t rx_in;
	logic rx_in_valid;
	logic rx_full;
	logic rx_empty;
	logic rx_push;
	logic rx_pop;
	logic rx_drop;
	logic tx_full;
	logic tx_push;
	logic tx_lost;
	logic tx_take;
	logic tx_pull;
	logic hold_empty;
	logic rdy;
	logic [5:0] tx_used;

	assign fifo_en = fc_q[`USD_FC_EN_BIT];
	assign done = psel && penable && pready_q;
	assign wr_done = done && pwrite;
	assign rd_done = done && !pwrite;
	assign slot_wr = wr_done && is_slot(paddr);
	assign slot_rd = rd_done && is_slot(paddr);
	assign fc_wr = wr_done && (paddr == `USD_FIFO_CTRL_OFS);

	// Changing the fifo enable flushes both fifos; each clear bit flushes only its own fifo.
	assign rx_flush = fc_wr && (pwdata[`USD_FC_RXCLR_BIT] ||
		(pwdata[`USD_FC_EN_BIT] != fifo_en));
	assign tx_flush = fc_wr && (pwdata[`USD_FC_TXCLR_BIT] ||
		(pwdata[`USD_FC_EN_BIT] != fifo_en));

	// Pick the serial or the infrared receiver by mode.
	assign rx_in = fc_q[`USD_FC_IR_BIT] ? rx_ir_char : rx_serial_char;
	assign rx_in_valid = fc_q[`USD_FC_IR_BIT] ? rx_ir_valid : rx_serial_valid;

	// Receive fifo control; a full fifo keeps its contents.
	assign rx_full = rx_cnt == `USD_FIFO_CW'(`USD_FIFO_DEPTH);
	assign rx_empty = rx_cnt == '0;
	assign rx_pop = fifo_en && slot_rd && !rx_empty;
	assign rx_drop = fifo_en && rx_in_valid && rx_full;
	assign rx_push = fifo_en && rx_in_valid && !rx_full;

	// Transmit path. The output stage counts toward the depth so that the
	// path holds exactly sixteen characters however fast the line drains.
	assign tx_take = tx_valid_q && tx_ready;
	assign tx_used = 6'(tx_cnt) + 6'(tx_valid_q);
	assign tx_full = tx_used >= 6'(`USD_FIFO_DEPTH);
	assign tx_push = fifo_en && slot_wr && !tx_full;
	assign tx_lost = fifo_en && slot_wr && tx_full;
	assign tx_pull = fifo_en && (tx_cnt != '0) && (!tx_valid_q || tx_take);

	// Flags as software sees them in each mode.
	assign hold_empty = fifo_en ? (tx_cnt == '0) : !tx_valid_q;
	assign rdy = fifo_en ? !rx_empty : rdy_q;

	usd_fifo u_rx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(rx_flush),
		.push(rx_push),
		.din(rx_in),
		.pop(rx_pop),
		.head(rx_head),
		.count(rx_cnt)
	);

	usd_fifo u_tx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(tx_flush),
		.push(tx_push),
		.din(pwdata[7:0]),
		.pop(tx_pull),
		.head(tx_head),
		.count(tx_cnt)
	);

	// Bus slave: one wait cycle, then the answer is held for one edge.
	// Read data is captured in the wait cycle, so pops happen at completion.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= usd_pkg::USD_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= `USD_SLOT_RST;
		end else begin
			case (st_q)
				usd_pkg::USD_IDLE: begin
					if (psel && !penable) begin
						st_q <= usd_pkg::USD_WAIT;
					end
				end
				usd_pkg::USD_WAIT: begin
					// Every slot aliases the same data; upper bits are zero.
					prdata_q <= '0;
					if (!pwrite && is_slot(paddr)) begin
						prdata_q[7:0] <= fifo_en ? rx_head : rx_hold_q;
					end else if (!pwrite && paddr == `USD_LINE_STATE_OFS) begin
						prdata_q[`USD_LS_READY_BIT] <= rdy;
						prdata_q[`USD_LS_OVR_BIT] <= ovr_q;
						prdata_q[`USD_LS_HOLD_EMPTY_BIT] <= hold_empty;
					end else if (!pwrite && paddr == `USD_FIFO_CTRL_OFS) begin
						prdata_q[`USD_FC_EN_BIT] <= fc_q[`USD_FC_EN_BIT];
						prdata_q[`USD_FC_IR_BIT] <= fc_q[`USD_FC_IR_BIT];
					end else if (!pwrite && paddr == `USD_INT_STS_OFS) begin
						prdata_q[`USD_IS_W-1:0] <= sts_q;
					end else if (!pwrite && paddr == `USD_INT_MASK_OFS) begin
						prdata_q[`USD_IS_W-1:0] <= mask_q;
					end
					pslverr_q <= !is_mapped(paddr);
					pready_q <= 1'b1;
					st_q <= usd_pkg::USD_DONE;
				end
				usd_pkg::USD_DONE: begin
					pready_q <= 1'b0;
					pslverr_q <= 1'b0;
					st_q <= usd_pkg::USD_IDLE;
				end
				default: begin
					pready_q <= 1'b0;
					st_q <= usd_pkg::USD_IDLE;
				end
			endcase
		end
	end

	// Fifo control; the clear bits act once and are not stored.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fc_q <= `USD_FC_RST;
		end else if (fc_wr) begin
			fc_q <= '0;
			fc_q[`USD_FC_EN_BIT] <= pwdata[`USD_FC_EN_BIT];
			fc_q[`USD_FC_IR_BIT] <= pwdata[`USD_FC_IR_BIT];
		end
	end

	// Non fifo receive holding byte. An unread byte is simply replaced,
	// so software that reads late loses the older character.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_hold_q <= '0;
			rdy_q <= 1'b0;
		end else if (rx_flush) begin
			rdy_q <= 1'b0;
		end else if (!fifo_en && rx_in_valid) begin
			rx_hold_q <= rx_in;
			rdy_q <= 1'b1;
		end else if (!fifo_en && slot_rd) begin
			rdy_q <= 1'b0;
		end
	end

	// Overrun flag: set by either mode, cleared by reading line state.
	// A new overrun in the clearing cycle wins over the clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovr_q <= 1'b0;
		end else if ((!fifo_en && rx_in_valid && rdy_q && !slot_rd) || rx_drop) begin
			ovr_q <= 1'b1;
		end else if (rd_done && paddr == `USD_LINE_STATE_OFS) begin
			ovr_q <= 1'b0;
		end
	end

	// Transmit output stage. Without fifos a write lands here directly and
	// overwrites any character not yet taken by the serializer.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_char_q <= '0;
			tx_valid_q <= 1'b0;
		end else if (tx_flush) begin
			tx_valid_q <= 1'b0;
		end else if (!fifo_en && slot_wr) begin
			tx_char_q <= pwdata[7:0];
			tx_valid_q <= 1'b1;
		end else if (tx_pull) begin
			tx_char_q <= tx_head;
			tx_valid_q <= 1'b1;
		end else if (tx_take) begin
			tx_valid_q <= 1'b0;
		end
	end

	// Sticky interrupt status, write one to clear; a set wins the clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sts_q <= '0;
			hold_empty_prev_q <= 1'b1;
		end else begin
			hold_empty_prev_q <= hold_empty;
			for (int i = 0; i < `USD_IS_W; i++) begin
				if (wr_done && paddr == `USD_INT_STS_OFS && pwdata[i]) begin
					sts_q[i] <= 1'b0;
				end
			end
			if (rx_in_valid) begin
				sts_q[`USD_IS_RX_BIT] <= 1'b1;
			end
			if ((!fifo_en && rx_in_valid && rdy_q && !slot_rd) || rx_drop) begin
				sts_q[`USD_IS_OVR_BIT] <= 1'b1;
			end
			if (hold_empty && !hold_empty_prev_q) begin
				sts_q[`USD_IS_HOLD_EMPTY_BIT] <= 1'b1;
			end
			if (tx_lost) begin
				sts_q[`USD_IS_LOST_BIT] <= 1'b1;
			end
		end
	end

	// Interrupt mask and the registered interrupt level.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= `USD_MASK_RST;
			irq_q <= 1'b0;
		end else begin
			if (wr_done && paddr == `USD_INT_MASK_OFS) begin
				mask_q <= pwdata[`USD_IS_W-1:0];
			end
			irq_q <= |(sts_q & mask_q);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign tx_char = tx_char_q;
	assign tx_valid = tx_valid_q;
	assign ir_mode = fc_q[`USD_FC_IR_BIT];
	assign irq = irq_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// The access phase sees pready one cycle after it opens.
	sequence s_open;
		psel && penable && !pready_q;
	endsequence
	property p_one_wait;
		s_open |=> pready_q;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("slave did not answer");

	property p_alias;
		(st_q == usd_pkg::USD_WAIT) && !pwrite && is_slot(paddr) && !fifo_en
			|=> prdata_q[7:0] == $past(rx_hold_q);
	endproperty
	a_alias: assert property (p_alias) else $error("slot read wrong byte");

	property p_upper_zero;
		pready_q && is_slot(paddr) |-> prdata_q[31:8] == 24'h00_0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("reserved bits set");

	property p_overwrite_rx;
		!fifo_en && rdy_q && rx_in_valid && !slot_rd && !rx_flush
			|=> ovr_q && rdy_q && rx_hold_q == $past(rx_in);
	endproperty
	a_overwrite_rx: assert property (p_overwrite_rx) else $error("no overrun");

	property p_pop;
		rx_pop && !rx_push && !rx_flush |=> rx_cnt == $past(rx_cnt) - 5'h01;
	endproperty
	a_pop: assert property (p_pop) else $error("read did not pop");

	property p_rx_drop;
		fifo_en && rx_full && rx_in_valid && !rx_pop && !rx_flush
			|=> ovr_q && rx_full;
	endproperty
	a_rx_drop: assert property (p_rx_drop) else $error("full fifo changed");

	property p_hold_clear;
		!fifo_en && hold_empty && slot_wr && !tx_flush |=> !hold_empty && tx_valid_q;
	endproperty
	a_hold_clear: assert property (p_hold_clear) else $error("holding empty stuck");

	property p_tx_over;
		!fifo_en && slot_wr && !tx_flush |=> tx_char_q == $past(pwdata[7:0]);
	endproperty
	a_tx_over: assert property (p_tx_over) else $error("pending char kept");

	property p_tx_accept;
		tx_push && !tx_pull && !tx_flush |=> tx_cnt == $past(tx_cnt) + 5'h01;
	endproperty
	a_tx_accept: assert property (p_tx_accept) else $error("write not queued");

	property p_tx_lost;
		tx_lost && !tx_pull && !tx_flush |=> tx_cnt == $past(tx_cnt) && sts_q[3];
	endproperty
	a_tx_lost: assert property (p_tx_lost) else $error("full fifo took write");

endmodule
`default_nettype wire

//--- include/usd_regs.svh
// Offsets, field positions, reset values and sizes of the shadow data port.
`ifndef USD_REGS_SVH
`define USD_REGS_SVH

// First and last of the sixteen aliased shadow data slots.
`define USD_SLOT_FIRST 32'h5000_1130
`define USD_SLOT_LAST 32'h5000_116C
// Slots whose offsets are printed for this port.
`define USD_SLOT2_OFS 32'h5000_1138
`define USD_SLOT3_OFS 32'h5000_113C
// Line state, fifo control, interrupt status and interrupt mask words.
`define USD_LINE_STATE_OFS 32'h5000_1180
`define USD_FIFO_CTRL_OFS 32'h5000_1184
`define USD_INT_STS_OFS 32'h5000_1188
`define USD_INT_MASK_OFS 32'h5000_118C

// Line state fields.
`define USD_LS_READY_BIT 0
`define USD_LS_OVR_BIT 1
`define USD_LS_HOLD_EMPTY_BIT 5
// Fifo control fields.
`define USD_FC_EN_BIT 0
`define USD_FC_RXCLR_BIT 1
`define USD_FC_TXCLR_BIT 2
`define USD_FC_IR_BIT 4
// Interrupt status fields.
`define USD_IS_RX_BIT 0
`define USD_IS_OVR_BIT 1
`define USD_IS_HOLD_EMPTY_BIT 2
`define USD_IS_LOST_BIT 3
`define USD_IS_W 4

// Reset values.
`define USD_SLOT_RST 32'h0000_0000
`define USD_FC_RST 5'h00
`define USD_MASK_RST 4'h0

// Fifo geometry: sixteen characters of eight bits.
`define USD_FIFO_DEPTH 16
`define USD_FIFO_AW 4
`define USD_FIFO_CW 5
`define USD_CHAR_W 8

`endif

//--- include/usd_pkg.sv
// Types shared by the shadow data port files.
package usd_pkg;

	// Phases of the register bus slave.
	typedef enum logic [1:0] {
		USD_IDLE = 2'b00,
		USD_WAIT = 2'b01,
		USD_DONE = 2'b10
	} usd_apb_e;

	// One character on the line.
	typedef logic [7:0] usd_char_t;

endpackage

//--- rtl/usd_fifo.sv
// Sixteen deep character fifo with flush, used for both directions.
`timescale 1ns/1ps
`default_nettype none
`include "usd_regs.svh"

module usd_fifo (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push,
	input wire usd_pkg::usd_char_t din,
	input wire logic pop,
	output usd_pkg::usd_char_t head,
	output logic [`USD_FIFO_CW-1:0] count
);

	// Storage array; contents need no reset since count guards them.
	usd_pkg::usd_char_t mem [`USD_FIFO_DEPTH];
	logic [`USD_FIFO_AW-1:0] wp_q;
	logic [`USD_FIFO_AW-1:0] rp_q;
	logic [`USD_FIFO_CW-1:0] cnt_q;
	logic do_push;
	logic do_pop;

	// The caller checks full and empty; these only guard the pointers, the count and the array write.
	assign do_push = push && (cnt_q != `USD_FIFO_CW'(`USD_FIFO_DEPTH));
	assign do_pop = pop && (cnt_q != '0);
	assign head = mem[rp_q];
	assign count = cnt_q;

	// Write the array on each accepted push.
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wp_q] <= din;
		end
	end

	// Pointers and count; flush empties the fifo without touching data.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (do_pop) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + `USD_FIFO_CW'(do_push) - `USD_FIFO_CW'(do_pop);
		end
	end

endmodule
`default_nettype wire

//--- bench/usd_far_end.sv
// Far end of the line: feeds received bytes and takes transmitted ones.
`timescale 1ns/1ps
`default_nettype none

module usd_far_end (
	input wire logic clk,
	input wire logic stall,
	output usd_pkg::usd_char_t ser_char,
	output logic ser_valid,
	output usd_pkg::usd_char_t ir_char,
	output logic ir_valid,
	input wire usd_pkg::usd_char_t tx_char,
	input wire logic tx_valid,
	output logic tx_ready
);
	// Characters taken from the design, oldest first.
	usd_pkg::usd_char_t got[$];

	// Lines start quiet so the design sees no arrival during reset.
	initial begin
		ser_char = 8'h00;
		ser_valid = 1'b0;
		ir_char = 8'h00;
		ir_valid = 1'b0;
		tx_ready = 1'b0;
	end

	// A stalled peer stops taking, which backs up the transmit path.
	always @(posedge clk) begin
		tx_ready <= !stall;
		if (tx_valid && tx_ready) begin
			got.push_back(tx_char);
		end
	end

	// Both receivers pulse at once with opposite bytes, so a wrong source shows.
	// Afterwards the lines swap bytes, so the selected line carries the inverse and the other the byte.
	task automatic send(input logic ir, input usd_pkg::usd_char_t b);
		@(posedge clk);
		ser_char <= ir ? ~b : b;
		ir_char <= ir ? b : ~b;
		ser_valid <= 1'b1;
		ir_valid <= 1'b1;
		@(posedge clk);
		ser_valid <= 1'b0;
		ir_valid <= 1'b0;
		ser_char <= ir ? b : ~b;
		ir_char <= ir ? ~b : b;
	endtask
endmodule

`default_nettype wire

//--- bench/test_uart_shadow_data_port.sv
// Register level test of the shadow data port against a far-end peer.
`timescale 1ns/1ps
`default_nettype none
`include "usd_regs.svh"

module test_uart_shadow_data_port;
	// Register words used below.
	localparam logic [31:0] s0 = `USD_SLOT_FIRST;
	localparam logic [31:0] ls = `USD_LINE_STATE_OFS;
	localparam logic [31:0] fc = `USD_FIFO_CTRL_OFS;
	localparam logic [31:0] st = `USD_INT_STS_OFS;
	localparam logic [31:0] mk = `USD_INT_MASK_OFS;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, stall, err;
	logic rx_sv, rx_iv, tx_valid, tx_ready, ir_mode, irq;
	logic [31:0] paddr, pwdata, prdata, rd_data;
	usd_pkg::usd_char_t rx_sc, rx_ic, tx_char;
	int fails, samples_checked, i;

	usd_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_serial_char(rx_sc), .rx_serial_valid(rx_sv), .rx_ir_char(rx_ic),
		.rx_ir_valid(rx_iv), .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.ir_mode(ir_mode), .irq(irq));

	usd_far_end far (.clk(clk), .stall(stall), .ser_char(rx_sc), .ser_valid(rx_sv),
		.ir_char(rx_ic), .ir_valid(rx_iv), .tx_char(tx_char), .tx_valid(tx_valid),
		.tx_ready(tx_ready));

	// Free running clock at 250 MHz.
	always #2 clk = ~clk;

	// Verdict and end of run.
	task automatic finish_test();
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Case equality, so an unknown never counts as a match.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One APB transfer; the request stands until pready is seen at an edge.
	// One idle edge follows, so no signal is assigned twice in one step.
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				fails++;
				finish_test();
			end
			@(posedge clk);
		end
		rd_data = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Read a word and compare the masked bits.
	task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd_data & m, exp);
	endtask

	// Wait, bounded, for the peer to hold k characters, then make sure no more follow.
	task automatic drain(input int k);
		int n;
		n = 0;
		while (far.got.size() < k && n < 300) begin
			n++;
			@(posedge clk);
		end
		tick(10);
		chk(far.got.size(), k);
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		stall = 1'b0;
		fails = 0;
		samples_checked = 0;
		tick(8);
		rst_n <= 1'b1;
		tick(1);
		rd(`USD_SLOT2_OFS, 32'hFFFF_FFFF, `USD_SLOT_RST);
		rd(ls, 32'h0000_0021, 32'h0000_0020);
		// Plain receive, then an unread byte overrun by the next one.
		far.send(1'b0, 8'hA5);
		rd(ls, 32'h0000_0001, 32'h0000_0001);
		rd(`USD_SLOT3_OFS, 32'hFFFF_FFFF, 32'h0000_00A5);
		rd(ls, 32'h0000_0001, 32'h0000_0000);
		far.send(1'b0, 8'h11);
		far.send(1'b0, 8'h22);
		rd(ls, 32'h0000_0002, 32'h0000_0002);
		rd(s0, 32'hFFFF_FFFF, 32'h0000_0022);
		// Infrared mode takes the infrared receiver only.
		apb(1'b1, fc, 32'h0000_0010);
		chk(ir_mode, 1'b1);
		far.send(1'b1, 8'h5A);
		rd(`USD_SLOT_LAST, 32'hFFFF_FFFF, 32'h0000_005A);
		apb(1'b1, fc, 32'h0000_0000);
		// Without fifos a second write replaces the pending character.
		stall <= 1'b1;
		apb(1'b1, `USD_SLOT2_OFS, 32'h0000_0011);
		apb(1'b1, `USD_SLOT3_OFS, 32'hFFFF_FF22);
		rd(ls, 32'h0000_0020, 32'h0000_0000);
		stall <= 1'b0;
		drain(1);
		chk(far.got[0], 32'h0000_0022);
		rd(ls, 32'h0000_0020, 32'h0000_0020);
		// Fifo mode: eighteen writes over all slots into a stalled peer.
		apb(1'b1, fc, 32'h0000_0001);
		stall <= 1'b1;
		for (i = 0; i < 18; i++) begin
			apb(1'b1, s0 + 32'(4 * (i % 16)), 32'(8'h40 + i));
		end
		rd(st, 32'h0000_0008, 32'h0000_0008);
		stall <= 1'b0;
		drain(17);
		for (i = 0; i < 16; i++) begin
			chk(far.got[i + 1], 32'(8'h40 + i));
		end
		// Seventeen arrivals into the sixteen deep receive fifo.
		for (i = 0; i < 17; i++) begin
			far.send(1'b0, 8'(8'h80 + i));
		end
		rd(ls, 32'h0000_0003, 32'h0000_0003);
		for (i = 0; i < 16; i++) begin
			rd(s0 + 32'(4 * i), 32'hFFFF_FFFF, 32'(8'h80 + i));
		end
		rd(ls, 32'h0000_0001, 32'h0000_0000);
		// Arrival and overrun events stay sticky until cleared.
		rd(st, 32'h0000_0003, 32'h0000_0003);
		// Interrupt raised, masked, unmasked and cleared.
		apb(1'b1, st, 32'h0000_000F);
		apb(1'b1, mk, 32'h0000_0001);
		far.send(1'b0, 8'h01);
		tick(2);
		chk(irq, 1'b1);
		apb(1'b1, mk, 32'h0000_0000);
		tick(2);
		chk(irq, 1'b0);
		apb(1'b1, mk, 32'h0000_0001);
		tick(2);
		chk(irq, 1'b1);
		apb(1'b1, st, 32'h0000_0001);
		tick(2);
		chk(irq, 1'b0);
		// Both flush bits empty the fifos while fifo mode stays on.
		apb(1'b1, fc, 32'h0000_0007);
		rd(ls, 32'h0000_0021, 32'h0000_0020);
		// An unmapped word is refused with an error and zero data.
		apb(1'b0, 32'h5000_1190, 32'h0000_0000);
		chk(err, 1'b1);
		chk(rd_data, 32'h0000_0000);
		finish_test();
	end
endmodule

`default_nettype wire
